// [rtl/lldi_device.sv]
// device-side command decode, bank timing, burst read and write datapath
`timescale 1ns/100ps
`default_nettype none
module lldi_device
  import lldi_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              arst_n_in,
  // command side
  input  wire logic              cmd_clk_in,
  input  wire logic              cs_n_in,
  input  wire logic              we_n_in,
  input  wire logic              ref_n_in,
  input  wire logic [BANK_W-1:0] bank_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // write data side
  input  wire logic              wdata_strobe_in,
  input  wire logic              wr_mask_in,
  input  wire logic [DQ_W-1:0]   dq_in,
  // read data side
  output logic      [DQ_W-1:0]   dq_out,
  output logic                   dq_oe_out,
  output logic                   rdata_strobe_out,
  output logic                   rd_valid_out,
  // settings and status
  output logic      [1:0]        burst_len_out,
  output logic      [2:0]        read_lat_out,
  output logic      [2:0]        row_cycle_out,
  output logic      [NBANK-1:0]  bank_busy_out,
  output logic      [ROW_W-1:0]  ref_row_out
);
  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] raw_v, sync_v, rise_v, fall_v;
  assign raw_v = {dq_in, addr_in, bank_in, wr_mask_in, ref_n_in,
                  we_n_in, cs_n_in, wdata_strobe_in, cmd_clk_in};

  // all pins share one pipeline so data keeps its place against edges
  lldi_sync3 #(.W(SYNC_W)) u_sync (
    .clk_in    (core_clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (raw_v),
    .q_out     (sync_v),
    .rise_out  (rise_v),
    .fall_out  (fall_v)
  );

  wire              cmd_rise = rise_v[S_CMDCLK];
  wire              ws_edge  = rise_v[S_WSTRB] | fall_v[S_WSTRB];
  wire              cs_n_s   = sync_v[S_CSN];
  wire              we_n_s   = sync_v[S_WEN];
  wire              ref_n_s  = sync_v[S_REFN];
  wire              mask_s   = sync_v[S_MASK];
  wire [BANK_W-1:0] bank_s   = sync_v[S_BANK +: BANK_W];
  wire [ADDR_W-1:0] addr_s   = sync_v[S_ADDR +: ADDR_W];
  wire [DQ_W-1:0]   dq_s     = sync_v[S_DQ +: DQ_W];

  // ----------------------------------------------------------------
  // settings and command decode
  // ----------------------------------------------------------------
  logic [1:0] burst_len_q;
  logic [2:0] read_lat_q, row_cycle_q;

  // burst word count from the length code; code 3 runs as eight
  function automatic logic [3:0] bl_words(input logic [1:0] code);
    unique case (code)
      2'h0:    bl_words = 4'h2;
      2'h1:    bl_words = 4'h4;
      default: bl_words = 4'h8;
    endcase
  endfunction : bl_words

  // chip select high blanks the decoder only
  wire cmd_sel = cmd_rise & ~cs_n_s;
  wire is_cfg  = cmd_sel & ~we_n_s & ~ref_n_s;
  wire is_wr   = cmd_sel & ~we_n_s &  ref_n_s;
  wire is_ref  = cmd_sel &  we_n_s & ~ref_n_s;
  wire is_rd   = cmd_sel &  we_n_s &  ref_n_s;

  logic [NBANK-1:0] bank_busy_q;
  logic [3:0]       rd_lat_q, rd_left_q, wr_lat_q, wr_left_q;
  wire bank_free = ~bank_busy_q[bank_s];
  // one burst of each direction in flight; others are dropped
  wire rd_go  = is_rd & bank_free & (rd_left_q == 4'h0);
  wire wr_go  = is_wr & bank_free & (wr_left_q == 4'h0);
  wire ref_go = is_ref & bank_free;
  wire [PTR_W-1:0] cmd_ptr = {bank_s, addr_s[COL_W-1:0]};

  // settings come off the address pins, not the array
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      burst_len_q <= BL_RST;
      read_lat_q  <= RL_RST;
      row_cycle_q <= RC_RST;
    end else if (is_cfg) begin
      burst_len_q <= addr_s[BL_LSB +: 2];
      read_lat_q  <= addr_s[RL_LSB +: 3];
      row_cycle_q <= addr_s[RC_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // per-bank row cycle timers and refresh row counters
  // ----------------------------------------------------------------
  logic [ROW_W-1:0] rows_q [NBANK];
  logic [ROW_W-1:0] ref_row_q;
  genvar gb;
  generate
    for (gb = 0; gb < NBANK; gb++) begin : g_bank
      logic [3:0] rc_q, rc_d;
      wire hit = (rd_go | wr_go | ref_go) & (bank_s == BANK_W'(gb));
      // each bank times its own row cycle so others stay usable
      assign rc_d = hit ? ({1'b0, row_cycle_q} + 4'h1)
                  : (cmd_rise && rc_q != 4'h0) ? rc_q - 4'h1 : rc_q;
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          rc_q            <= 4'h0;
          bank_busy_q[gb] <= 1'b0;
          rows_q[gb]      <= '0;
        end else begin
          rc_q            <= rc_d;
          bank_busy_q[gb] <= (rc_d != 4'h0);
          if (hit && ref_go)
            rows_q[gb] <= rows_q[gb] + 13'h0001;
        end
      end
    end
  endgenerate

  // report the row just refreshed
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      ref_row_q <= '0;
    else if (ref_go)
      ref_row_q <= rows_q[bank_s] + 13'h0001;
  end

  // ----------------------------------------------------------------
  // output strobe divider and array
  // ----------------------------------------------------------------
  logic [1:0]      div_q;
  logic            rstrb_q;
  wire             tick = (div_q == DIV_MAX);
  logic [DQ_W-1:0] mem [NBANK << COL_W];

  // free-running strobe, toggled every half period
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q   <= 2'h0;
      rstrb_q <= 1'b0;
    end else begin
      div_q   <= tick ? 2'h0 : div_q + 2'h1;
      rstrb_q <= rstrb_q ^ tick;
    end
  end

  // ----------------------------------------------------------------
  // read burst: latency in command clocks, then a word per strobe edge
  // ----------------------------------------------------------------
  logic [PTR_W-1:0] rd_ptr_q, wr_ptr_q;
  wire rd_fire = tick & (rd_lat_q == 4'h0) & (rd_left_q != 4'h0);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_lat_q  <= 4'h0;
      rd_left_q <= 4'h0;
      rd_ptr_q  <= '0;
    end else if (rd_go) begin
      rd_lat_q  <= {1'b0, read_lat_q};
      rd_left_q <= bl_words(burst_len_q);
      rd_ptr_q  <= cmd_ptr;
    end else begin
      if (cmd_rise && rd_lat_q != 4'h0)
        rd_lat_q <= rd_lat_q - 4'h1;
      if (rd_fire) begin
        rd_left_q <= rd_left_q - 4'h1;
        rd_ptr_q  <= {rd_ptr_q[PTR_W-1:COL_W], rd_ptr_q[COL_W-1:0] + 4'h1};
      end
    end
  end

  logic [DQ_W-1:0] dq_q;
  logic            oe_q, vld_q;
  // words change with each strobe edge, two per strobe cycle
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dq_q  <= '0;
      oe_q  <= 1'b0;
      vld_q <= 1'b0;
    end else if (tick) begin
      dq_q  <= rd_fire ? mem[rd_ptr_q] : dq_q;
      oe_q  <= rd_fire;
      vld_q <= rd_fire;
    end
  end

  // ----------------------------------------------------------------
  // write burst: same latency, a word per write strobe edge
  // ----------------------------------------------------------------
  wire wr_take = ws_edge & (wr_lat_q == 4'h0) & (wr_left_q != 4'h0);
  wire wr_en   = wr_take & ~mask_s;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_lat_q  <= 4'h0;
      wr_left_q <= 4'h0;
      wr_ptr_q  <= '0;
    end else if (wr_go) begin
      wr_lat_q  <= {1'b0, read_lat_q};
      wr_left_q <= bl_words(burst_len_q);
      wr_ptr_q  <= cmd_ptr;
    end else begin
      if (cmd_rise && wr_lat_q != 4'h0)
        wr_lat_q <= wr_lat_q - 4'h1;
      if (wr_take) begin
        wr_left_q <= wr_left_q - 4'h1;
        wr_ptr_q  <= {wr_ptr_q[PTR_W-1:COL_W], wr_ptr_q[COL_W-1:0] + 4'h1};
      end
    end
  end

  // array has no reset; a masked slot keeps its old word
  always_ff @(posedge core_clk_in) begin
    if (wr_en)
      mem[wr_ptr_q] <= dq_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dq_out           = dq_q;
  assign dq_oe_out        = oe_q;
  assign rdata_strobe_out = rstrb_q;
  assign rd_valid_out     = vld_q;
  assign burst_len_out    = burst_len_q;
  assign read_lat_out     = read_lat_q;
  assign row_cycle_out    = row_cycle_q;
  assign bank_busy_out    = bank_busy_q;
  assign ref_row_out      = ref_row_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  strobe_period_a: assert property ($changed(rstrb_q) |=>
    !$changed(rstrb_q) [*3] ##1 $changed(rstrb_q))
    else $error("read strobe half period wrong");
  ddr_word_a: assert property (rd_fire |=>
    oe_q && vld_q && $changed(rstrb_q) && dq_q == mem[$past(rd_ptr_q)])
    else $error("read word not launched on strobe edge");
  cmd_edge_a: assert property ((rd_go || wr_go || is_cfg)
    |-> $rose(sync_v[S_CMDCLK]) && !sync_v[S_CSN])
    else $error("command taken off a command clock rise");
  wr_store_a: assert property (wr_en |=>
    mem[$past(wr_ptr_q)] == $past(dq_s))
    else $error("write word not stored");
  burst_legal_a: assert property (rd_go |=>
    rd_left_q == 4'h2 || rd_left_q == 4'h4 || rd_left_q == 4'h8)
    else $error("illegal burst length");
  ref_row_a: assert property (ref_go |=>
    ref_row_q == $past(rows_q[bank_s]) + 13'h0001)
    else $error("refresh row not advanced");
  bank_busy_a: assert property ((is_rd && !bank_free
    && rd_left_q == 4'h0) |=> rd_left_q == 4'h0)
    else $error("read accepted by a busy bank");
  rd_latency_a: assert property (rd_go |->
    ##[1:100] rd_fire)
    else $error("read data late");
  cs_ignore_a: assert property ((cmd_rise && cs_n_s)
    |=> $stable(read_lat_q) && $stable(burst_len_q))
    else $error("command taken while deselected");
  mask_drop_a: assert property ((wr_take && mask_s) |=>
    mem[$past(wr_ptr_q)] == $past(mem[wr_ptr_q]))
    else $error("masked word was written");
  cfg_load_a: assert property (is_cfg |=>
    read_lat_q == $past(addr_s[RL_LSB +: 3]))
    else $error("read latency not loaded from address");

  cov_read_c:    cover property (rd_go ##[1:100] rd_fire);
  cov_write_c:   cover property (wr_go ##[1:100] wr_en);
  cov_refresh_c: cover property (ref_go);
  cov_mask_c:    cover property (wr_take && mask_s);
endmodule : lldi_device
`default_nettype wire

// [rtl/lldi_pkg.sv]
// constants for the low-latency dram interface device front end
//
// Behaviour
// - data pins carry two words per clock cycle, one per edge.
// - read data launches aligned to a free-running output strobe we drive.
// - command, address, control sampled on each rising command clock edge.
// - write data captured on both edges of the host write strobe.
// - every read and write is a burst of 2, 4 or 8 words.
// - eight independent banks; row cycles in different banks overlap, but only one read and one write burst run at a time.
// - read latency, row cycle and burst length are held settings.
// - chip select high ignores new commands; running work completes.
// - write, refresh and chip select inputs together encode the command.
// - a write word is dropped when the mask is sampled high.
// - a config set command loads settings from the address inputs.
package lldi_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DQ_W    = 9;
  localparam int ADDR_W  = 8;
  localparam int BANK_W  = 3;
  localparam int NBANK   = 8;
  localparam int COL_W   = 4;
  localparam int ROW_W   = 13;   // 8K refresh rows per bank
  localparam int PTR_W   = BANK_W + COL_W;
  localparam int SYNC_W  = 6 + BANK_W + ADDR_W + DQ_W;
  // ----------------------------------------------------------------
  // synchronised input vector bit positions
  // ----------------------------------------------------------------
  localparam int S_CMDCLK = 0;
  localparam int S_WSTRB  = 1;
  localparam int S_CSN    = 2;
  localparam int S_WEN    = 3;
  localparam int S_REFN   = 4;
  localparam int S_MASK   = 5;
  localparam int S_BANK   = 6;
  localparam int S_ADDR   = S_BANK + BANK_W;
  localparam int S_DQ     = S_ADDR + ADDR_W;
  // ----------------------------------------------------------------
  // config fields on the address inputs and reset values
  // ----------------------------------------------------------------
  localparam int BL_LSB  = 0;
  localparam int RL_LSB  = 2;
  localparam int RC_LSB  = 5;
  localparam logic [1:0] BL_RST = 2'h0;
  localparam logic [2:0] RL_RST = 3'h3;
  localparam logic [2:0] RC_RST = 3'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_NS     = 50;
  localparam int STROBE_HALF_NS  = 200;
  localparam int STROBE_HALF_CYC = STROBE_HALF_NS / CORE_CLK_NS;
  localparam logic [1:0] DIV_MAX = 2'(STROBE_HALF_CYC - 1);
endpackage : lldi_pkg

// [rtl/lldi_sync3.sv]
// three-stage input synchroniser with agreement filter and edge flags
`timescale 1ns/100ps
`default_nettype none
module lldi_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  // raw and filtered signals
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, f_q, f_d, prev_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  // a bit only moves once the second and third stage agree
  assign f_d = (agree & s3_q) | (~agree & f_q);

  // stage one feeds stage two only, nothing else looks at it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      f_q    <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= d_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      f_q    <= f_d;
      prev_q <= f_q;
    end
  end

  // edge flags
  assign q_out    = f_q;
  assign rise_out = f_q & ~prev_q;
  assign fall_out = ~f_q & prev_q;
endmodule : lldi_sync3
`default_nettype wire

// [verif/lldi_host_model.sv]
// host controller model: command clock, commands and write bursts
`timescale 1ns/100ps
`default_nettype none
module lldi_host_model
  import lldi_pkg::*;
(
  // command side
  output logic              cmd_clk_out,
  output logic              cs_n_out,
  output logic              we_n_out,
  output logic              ref_n_out,
  output logic [BANK_W-1:0] bank_out,
  output logic [ADDR_W-1:0] addr_out,
  // write data side
  output logic              wdata_strobe_out,
  output logic              wr_mask_out,
  output logic [DQ_W-1:0]   dq_out
);
  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  // both run free; the strobe lags a quarter period so that data,
  // which changes on command clock edges, sits midway between edges
  initial begin
    cmd_clk_out = 1'b0;
    cs_n_out    = 1'b1;
    we_n_out    = 1'b1;
    ref_n_out   = 1'b1;
    bank_out    = '0;
    addr_out    = '0;
    wr_mask_out = 1'b0;
    dq_out      = '0;
    wdata_strobe_out = 1'b0;
    #100;
    forever #200 wdata_strobe_out = ~wdata_strobe_out;
  end
  always #200 cmd_clk_out = ~cmd_clk_out;
  // ---------------------------------------------------------------
  // one command, valid from the fall before its rise to the fall after
  // ---------------------------------------------------------------
  task automatic cmd(input logic cs_n, input logic [1:0] kind,
                     input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
    @(negedge cmd_clk_out);
    cs_n_out = cs_n;
    {we_n_out, ref_n_out} = kind;
    bank_out = b;
    addr_out = a;
    @(posedge cmd_clk_out);
    @(negedge cmd_clk_out);
    cs_n_out = 1'b1;
    {we_n_out, ref_n_out} = 2'b11;
    addr_out = ~a; // released lines never keep the old value
    bank_out = ~b;
  endtask : cmd
  // ---------------------------------------------------------------
  // write burst: latency in command rises, then one word per edge
  // ---------------------------------------------------------------
  task automatic wburst(input int rl, input int n,
                        input logic [7:0][DQ_W-1:0] w, input logic [7:0] m);
    repeat (rl) @(posedge cmd_clk_out);
    for (int i = 0; i < n; i++) begin
      if (i > 0) @(cmd_clk_out);
      dq_out = w[i];
      wr_mask_out = m[i];
    end
    @(cmd_clk_out);
    dq_out = ~dq_out;
    wr_mask_out = 1'b0;
  endtask : wburst
endmodule : lldi_host_model
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the dram device front end
`timescale 1ns/100ps
`default_nettype none
module tb;
  import lldi_pkg::*;
  logic              core_clk_in, arst_n_in;
  logic              cmd_clk, cs_n, we_n, ref_n, wstrb, mask;
  logic              oe, rstrb, rd_valid;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   host_dq, dev_dq, dq_pin;
  logic [1:0]        bl;
  logic [2:0]        rl, rc;
  logic [NBANK-1:0]  busy;
  logic [ROW_W-1:0]  ref_row;
  logic [DQ_W-1:0]   rx_q[$];
  logic              strb_q;
  int                n_mismatch, compares, cyc, last_t, first_c, cur_rl;
  // the shared data wire: the device drives it while its enable is high, the host otherwise
  assign dq_pin = oe ? dev_dq : host_dq;
  lldi_device u_lldi_device (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .cmd_clk_in(cmd_clk), .cs_n_in(cs_n), .we_n_in(we_n), .ref_n_in(ref_n),
    .bank_in(bank), .addr_in(addr), .wdata_strobe_in(wstrb),
    .wr_mask_in(mask), .dq_in(dq_pin), .dq_out(dev_dq), .dq_oe_out(oe),
    .rdata_strobe_out(rstrb), .rd_valid_out(rd_valid), .burst_len_out(bl),
    .read_lat_out(rl), .row_cycle_out(rc), .bank_busy_out(busy),
    .ref_row_out(ref_row));
  lldi_host_model u_lldi_host_model (.cmd_clk_out(cmd_clk), .cs_n_out(cs_n),
    .we_n_out(we_n), .ref_n_out(ref_n), .bank_out(bank), .addr_out(addr),
    .wdata_strobe_out(wstrb), .wr_mask_out(mask), .dq_out(host_dq));
  // ---------------------------------------------------------------
  // clock, compare and close
  // ---------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // read capture: one word per strobe toggle while valid
  // ---------------------------------------------------------------
  always @(negedge core_clk_in) begin
    cyc++;
    if (rstrb !== strb_q) begin
      if (last_t > 0) chk("strobe half", cyc - last_t, 4);
      last_t = cyc;
      if (rd_valid === 1'b1) begin
        if (rx_q.size() == 0) first_c = cyc;
        rx_q.push_back(dev_dq);
        chk("dq drive", oe, 1);
      end
    end
    // a half period never spans reset, so the first toggle after it is free
    if (arst_n_in !== 1'b1) last_t = 0;
    strb_q = rstrb;
  end
  // ---------------------------------------------------------------
  // shared bus operations
  // ---------------------------------------------------------------
  task automatic cfg(input logic [1:0] code);
    u_lldi_host_model.cmd(1'b0, 2'b00, 3'h0, {3'h2, 3'h4, code});
    cur_rl = 4;
    repeat (10) @(negedge core_clk_in);
    chk("burst code", bl, code);
    chk("latency set", rl, 4);
    chk("row cycle", rc, 2);
  endtask : cfg
  task automatic wr(input logic [2:0] b, input logic [3:0] col, input int n,
                    input logic [7:0][DQ_W-1:0] w, input logic [7:0] m);
    u_lldi_host_model.cmd(1'b0, 2'b01, b, {4'h0, col});
    u_lldi_host_model.wburst(cur_rl, n, w, m);
    repeat (3) @(posedge cmd_clk);
  endtask : wr
  task automatic rd(input logic [2:0] b, input logic [3:0] col, input int n,
                    input logic [7:0][DQ_W-1:0] ex);
    int t;
    rx_q.delete();
    u_lldi_host_model.cmd(1'b0, 2'b11, b, {4'h0, col});
    t = cyc;
    repeat (8 * cur_rl + 4 * n + 40) @(negedge core_clk_in);
    chk("words", rx_q.size(), n);
    chk("read wait", (first_c - t >= 8 * cur_rl - 6)
        && (first_c - t <= 8 * cur_rl + 16), 1);
    for (int i = 0; i < n; i++) chk("rd word", rx_q[i], ex[i]);
  endtask : rd
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset();
    chk("bl reset", bl, BL_RST);
    chk("rl reset", rl, RL_RST);
    chk("busy reset", busy, 0);
  endtask : sc_reset
  // every burst code, wrapping column, written then read back
  task automatic sc_bursts();
    logic [7:0][DQ_W-1:0] w;
    int n;
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 2 : (c == 1) ? 4 : 8;
      for (int i = 0; i < 8; i++) w[i] = 9'(c * 16 + i + 1);
      cfg(2'(c));
      wr(3'(c + 1), 4'hE, n, w, 8'h00);
      rd(3'(c + 1), 4'hE, n, w);
    end
  endtask : sc_bursts
  // masked words keep what the first burst stored
  task automatic sc_mask();
    logic [7:0][DQ_W-1:0] a, b, ex;
    for (int i = 0; i < 8; i++) begin
      a[i] = 9'(i + 9'h0A0);
      b[i] = 9'(i + 9'h150);
      ex[i] = (i % 3 == 0) ? a[i] : b[i];
    end
    wr(3'h6, 4'hC, 8, a, 8'h00);
    wr(3'h6, 4'hC, 8, b, 8'h49);
    rd(3'h6, 4'hC, 8, ex);
  endtask : sc_mask
  // deselected commands do nothing
  task automatic sc_ignore();
    rx_q.delete();
    u_lldi_host_model.cmd(1'b1, 2'b11, 3'h6, 8'h0C);
    // settings differ from the live ones so a wrong load would show
    u_lldi_host_model.cmd(1'b1, 2'b00, 3'h0, 8'h00);
    repeat (80) @(negedge core_clk_in);
    chk("no read", rx_q.size(), 0);
    chk("no config", bl, 3);
    chk("no latency", rl, 4);
  endtask : sc_ignore
  // per bank row counters, two banks busy together
  task automatic sc_refresh();
    logic [ROW_W-1:0] r0;
    u_lldi_host_model.cmd(1'b0, 2'b10, 3'h2, 8'h00);
    repeat (6) @(negedge core_clk_in);
    r0 = ref_row;
    repeat (4) @(posedge cmd_clk);
    u_lldi_host_model.cmd(1'b0, 2'b10, 3'h2, 8'h00);
    repeat (6) @(negedge core_clk_in);
    chk("row step", ref_row, r0 + 1'b1);
    u_lldi_host_model.cmd(1'b0, 2'b10, 3'h5, 8'h00);
    repeat (3) @(negedge core_clk_in);
    chk("two busy", {busy[2], busy[5]}, 2'b11);
    repeat (3) @(negedge core_clk_in);
    chk("own row", ref_row, r0);
    // bank five is still in its row cycle, so this read must be dropped
    rx_q.delete();
    u_lldi_host_model.cmd(1'b0, 2'b11, 3'h5, 8'h00);
    repeat (80) @(negedge core_clk_in);
    chk("busy drop", rx_q.size(), 0);
  endtask : sc_refresh
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    arst_n_in = 1'b0;
    repeat (12) @(posedge core_clk_in);
    #5 arst_n_in = 1'b1;
    sc_reset();
    repeat (20) @(posedge core_clk_in);
    sc_bursts();
    sc_mask();
    sc_ignore();
    sc_refresh();
    close_out();
  end
  initial begin
    #3_000_000;
    n_mismatch++;
    close_out();
  end
endmodule : tb
`default_nettype wire
